/* File: hdl/ring_defs.svh */
// Purpose: shared constants for the status ring exchange
// Assumes: 40 MHz system clock, word-indexed register port
// Notes:   frame is start bit, id byte, 16 status bits, crc32, stop bit
`ifndef RING_DEFS_SVH
`define RING_DEFS_SVH

`define CLK_HZ        40000000
`define RATE_LO_BPS   64000
`define RATE_HI_BPS   128000
`define BIT_CYC_LO    (`CLK_HZ / `RATE_LO_BPS)
`define BIT_CYC_HI    (`CLK_HZ / `RATE_HI_BPS)
`define MS_CYC        (`CLK_HZ / 1000)

`define INTEG_MAX_MS  500
`define INTEG_LO_MS   490
`define INTEG_HI_MS   245
`define TIMEOUT_MS    1500

`define PAYLOAD_BITS  24
`define CRC_BITS      32
`define FRAME_BITS    57
`define CRC_POLY      32'h04C11DB7
`define CRC_INIT      32'hFFFFFFFF

`define REG_CTRL      4'h0
`define REG_ID        4'h1
`define REG_OUT_STAT  4'h2
`define REG_PEER_CFG  4'h3
`define REG_FLAGS     4'h4
`define REG_RX_LAST   4'h5
`define REG_IRQ_STAT  4'h6
`define REG_IRQ_MASK  4'h7

`define CTRL_ENABLE   0
`define CTRL_RATE_HI  1
`define CTRL_RING_EN  2
`define CTRL_BRIDGE   3
`define CTRL_RESET    4'h0

`define IRQ_RX_MSG    0
`define IRQ_CRC_ERR   1
`define IRQ_RING_BRK  2
`define IRQ_PEER_OFF  3

`endif

/* File: hdl/ring_pkg.sv */
// Purpose: types and shared functions for the status ring exchange
// Assumes: ring_defs.svh supplies the numeric constants
// Notes:   crc is msb-first, no reflection, no final inversion
`include "ring_defs.svh"

package ring_pkg;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10
  } rx_state_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_t;

  function automatic logic [31:0] crc32_24(input logic [23:0] d);
    logic [31:0] c;
    c = `CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      c = (c[31] ^ d[i]) ? ((c << 1) ^ `CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc32_24

  function automatic logic is_own(input logic [7:0] id, input logic [3:0] sid);
    return id == {4'h0, sid};
  endfunction : is_own

endpackage : ring_pkg

/* File: hdl/ring_frame_rx.sv */
// Purpose: receive one channel's serial frames and check their crc
// Assumes: idle-high line, bit period given in clk_i cycles
// Notes:   pulses valid_o or crc_err_o for one cycle per frame
`timescale 1ns/1ps
`include "ring_defs.svh"

module ring_frame_rx #(
  parameter int CNT_W = 10
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [CNT_W-1:0] bit_cyc_i,
  input  wire logic             line_i,
  output logic                  valid_o,
  output logic                  crc_err_o,
  output logic [7:0]            id_o,
  output logic [15:0]           stat_o
);
  import ring_pkg::*;

  localparam int DB = `PAYLOAD_BITS + `CRC_BITS;

  typedef struct packed {
    logic             sync1;
    logic             sync2;
    rx_state_t        st;
    logic [CNT_W-1:0] cnt;
    logic [5:0]       nbit;
    logic [DB-1:0]    shr;
    logic             valid;
    logic             crc_err;
  } rx_regs_t;

  rx_regs_t s;
  rx_regs_t next_s;

  always_comb begin
    logic good;
    good = 1'b0;
    next_s = s;
    next_s.sync1 = line_i;
    next_s.sync2 = s.sync1;
    next_s.valid = 1'b0;
    next_s.crc_err = 1'b0;
    unique case (s.st)
      RX_IDLE: begin
        if (!s.sync2) begin
          next_s.st = RX_START;
          next_s.cnt = bit_cyc_i >> 1;
        end
      end
      RX_START: begin
        if (s.cnt != '0) begin
          next_s.cnt = s.cnt - 1'b1;
        end else if (s.sync2) begin
          // glitch shorter than half a bit
          next_s.st = RX_IDLE;
        end else begin
          next_s.st = RX_DATA;
          next_s.cnt = bit_cyc_i - 1'b1;
          next_s.nbit = '0;
        end
      end
      RX_DATA: begin
        if (s.cnt != '0) begin
          next_s.cnt = s.cnt - 1'b1;
        end else begin
          next_s.cnt = bit_cyc_i - 1'b1;
          next_s.nbit = s.nbit + 1'b1;
          if (s.nbit == 6'(`FRAME_BITS - 1)) begin
            good = s.sync2 && (crc32_24(s.shr[DB-1:`CRC_BITS]) == s.shr[`CRC_BITS-1:0]);
            next_s.valid = good;
            next_s.crc_err = !good;
            next_s.st = RX_IDLE;
          end else begin
            next_s.shr = {s.shr[DB-2:0], s.sync2};
          end
        end
      end
      default: next_s.st = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
      s.sync1 <= 1'b1;
      s.sync2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign valid_o = s.valid;
  assign crc_err_o = s.crc_err;
  assign id_o = s.shr[DB-1:DB-8];
  assign stat_o = s.shr[DB-9:`CRC_BITS];

endmodule : ring_frame_rx

/* File: hdl/ring_status_message_exchange.sv */
// Purpose: status message framer for a relay-to-relay ring link
// Assumes: 40 MHz clk_i, idle-high serial lines at 64 or 128 kbps
// Notes:   store-and-forward, one shared serializer for both channels
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "ring_defs.svh"

module ring_status_message_exchange #(
  parameter int CHANNELS   = 2,
  parameter int MS_CYC     = `MS_CYC,
  parameter int TIMEOUT_MS = `TIMEOUT_MS
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [31:0] rdata_o,
  input  wire logic        ch1_rx_i,
  input  wire logic        ch2_rx_i,
  output logic             ch1_tx_o,
  output logic             ch2_tx_o,
  output logic             ring_break_o,
  output logic             peer_offline_o,
  output logic             irq_o
);
  import ring_pkg::*;

  localparam int TX_W = `FRAME_BITS + 1;

  if (CHANNELS < 1 || CHANNELS > 2) begin : g_bad_channels
    $error("CHANNELS must be 1 or 2");
  end
  if (MS_CYC < 2 || MS_CYC > 65535) begin : g_bad_ms
    $error("MS_CYC out of range");
  end
  if (TIMEOUT_MS <= 2 * `INTEG_MAX_MS || TIMEOUT_MS > 2047) begin : g_bad_timeout
    $error("TIMEOUT_MS out of range");
  end

  typedef struct packed {
    logic [3:0]        ctrl;
    logic [3:0]        sid;
    logic [15:0]       out_stat;
    logic [15:0]       peer_cfg;
    logic [3:0]        irq_stat;
    logic [3:0]        irq_mask;
    logic [31:0]       rdata;
    logic [15:0]       ms_cnt;
    logic [15:0][10:0] age;
    logic [10:0]       ring_age;
    logic [8:0]        integ_ms;
    logic              own_pend;
    logic [1:0]        fwd_pend;
    logic [1:0][23:0]  fwd_msg;
    logic [7:0]        last_id;
    logic [15:0]       last_stat;
    tx_state_t         tst;
    logic [9:0]        bcnt;
    logic [5:0]        tbit;
    logic [TX_W-1:0]   tshr;
    logic [1:0]        tmask;
    logic              tx1;
    logic              tx2;
    logic              ring_break;
    logic              peer_off;
    logic              irq;
  } st_t;

  st_t s;
  st_t next_s;

  logic [9:0]  bit_cyc;
  logic [1:0]  rx_ok;
  logic [1:0]  rx_bad;
  logic [7:0]  rx_id [2];
  logic [15:0] rx_stat [2];

  assign bit_cyc = s.ctrl[`CTRL_RATE_HI] ? 10'(`BIT_CYC_HI) : 10'(`BIT_CYC_LO);

  ring_frame_rx #(.CNT_W(10)) u_rx1 (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .bit_cyc_i (bit_cyc),
    .line_i    (ch1_rx_i),
    .valid_o   (rx_ok[0]),
    .crc_err_o (rx_bad[0]),
    .id_o      (rx_id[0]),
    .stat_o    (rx_stat[0])
  );

  ring_frame_rx #(.CNT_W(10)) u_rx2 (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .bit_cyc_i (bit_cyc),
    .line_i    (ch2_rx_i),
    .valid_o   (rx_ok[1]),
    .crc_err_o (rx_bad[1]),
    .id_o      (rx_id[1]),
    .stat_o    (rx_stat[1])
  );

  always_comb begin
    logic        en;
    logic        tick;
    logic [1:0]  ok;
    logic [15:0] online;
    logic [3:0]  ev;
    logic [3:0]  clr;
    logic [23:0] pay;
    logic [1:0]  own_mask;
    logic [1:0]  fwd0_mask;
    en = s.ctrl[`CTRL_ENABLE];
    ok = en ? (rx_ok & ((CHANNELS == 2) ? 2'b11 : 2'b01)) : 2'b00;
    online = '0;
    ev = '0;
    clr = '0;
    pay = '0;
    own_mask = (CHANNELS == 2) ? 2'b11 : 2'b01;
    fwd0_mask = {(CHANNELS == 2) && s.ctrl[`CTRL_BRIDGE], 1'b1};
    next_s = s;
    next_s.rdata = '0;

    tick = (s.ms_cnt == 16'(MS_CYC - 1));
    next_s.ms_cnt = tick ? '0 : s.ms_cnt + 1'b1;

    for (int i = 0; i < 16; i++) begin
      if (!en) begin
        next_s.age[i] = '0;
      end else if ((ok[0] && rx_id[0] == 8'(i) && !is_own(rx_id[0], s.sid)) ||
                   (ok[1] && rx_id[1] == 8'(i) && !is_own(rx_id[1], s.sid))) begin
        next_s.age[i] = '0;
      end else if (tick && s.age[i] < 11'(TIMEOUT_MS)) begin
        next_s.age[i] = s.age[i] + 1'b1;
      end
      online[i] = s.age[i] < 11'(TIMEOUT_MS);
    end

    if (!en || !s.ctrl[`CTRL_RING_EN]) begin
      next_s.ring_age = '0;
    end else if ((ok[0] && is_own(rx_id[0], s.sid)) || (ok[1] && is_own(rx_id[1], s.sid))) begin
      next_s.ring_age = '0;
    end else if (tick && s.ring_age < 11'(TIMEOUT_MS)) begin
      next_s.ring_age = s.ring_age + 1'b1;
    end
    next_s.ring_break = en && s.ctrl[`CTRL_RING_EN] && s.ring_age >= 11'(TIMEOUT_MS);
    next_s.peer_off = en && |(s.peer_cfg & ~online);

    if (ok[0]) begin
      next_s.last_id = rx_id[0];
      next_s.last_stat = rx_stat[0];
    end else if (ok[1]) begin
      next_s.last_id = rx_id[1];
      next_s.last_stat = rx_stat[1];
    end

    if (tick && s.integ_ms != '1) begin
      next_s.integ_ms = s.integ_ms + 1'b1;
    end

    unique case (s.tst)
      TX_IDLE: begin
        next_s.tmask = '0;
        if (en && s.own_pend) begin
          pay = {4'h0, s.sid, s.out_stat};
          next_s.own_pend = 1'b0;
          next_s.integ_ms = '0;
          next_s.tmask = own_mask;
        end else if (en && s.fwd_pend[0]) begin
          pay = s.fwd_msg[0];
          next_s.fwd_pend[0] = 1'b0;
          next_s.tmask = fwd0_mask;
        end else if (en && s.fwd_pend[1]) begin
          pay = s.fwd_msg[1];
          next_s.fwd_pend[1] = 1'b0;
          next_s.tmask = 2'b10;
        end
        if (next_s.tmask != 2'b00) begin
          next_s.tst = TX_SEND;
          next_s.tshr = {1'b0, pay, crc32_24(pay), 1'b1};
          next_s.bcnt = bit_cyc - 1'b1;
          next_s.tbit = '0;
        end
      end
      TX_SEND: begin
        if (s.bcnt != '0) begin
          next_s.bcnt = s.bcnt - 1'b1;
        end else if (s.tbit == 6'(TX_W - 1)) begin
          next_s.tst = TX_IDLE;
          next_s.tmask = '0;
        end else begin
          next_s.bcnt = bit_cyc - 1'b1;
          next_s.tbit = s.tbit + 1'b1;
          next_s.tshr = {s.tshr[TX_W-2:0], 1'b1};
        end
      end
    endcase

    // pending sets come after the loads so a new event is never lost
    // next value, so the load that just cleared the count does not re-arm a second frame
    if (en && next_s.integ_ms >= (s.ctrl[`CTRL_RATE_HI] ? 9'(`INTEG_HI_MS) : 9'(`INTEG_LO_MS))) begin
      next_s.own_pend = 1'b1;
    end
    if (we_i && addr_i == `REG_OUT_STAT && wdata_i[15:0] != s.out_stat) begin
      next_s.own_pend = 1'b1;
    end
    for (int c = 0; c < 2; c++) begin
      if (ok[c] && !is_own(rx_id[c], s.sid)) begin
        next_s.fwd_pend[c] = 1'b1;
        next_s.fwd_msg[c] = {rx_id[c], rx_stat[c]};
      end
    end

    next_s.tx1 = !(next_s.tst == TX_SEND && next_s.tmask[0]) || next_s.tshr[TX_W-1];
    next_s.tx2 = !(next_s.tst == TX_SEND && next_s.tmask[1]) || next_s.tshr[TX_W-1];

    if (we_i) begin
      unique case (addr_i)
        `REG_CTRL:     next_s.ctrl = wdata_i[3:0];
        `REG_ID:       next_s.sid = wdata_i[3:0];
        `REG_OUT_STAT: next_s.out_stat = wdata_i[15:0];
        `REG_PEER_CFG: next_s.peer_cfg = wdata_i[15:0];
        `REG_IRQ_STAT: clr = wdata_i[3:0];
        `REG_IRQ_MASK: next_s.irq_mask = wdata_i[3:0];
        default: ;
      endcase
    end
    if (re_i) begin
      unique case (addr_i)
        `REG_CTRL:     next_s.rdata = {28'h0, s.ctrl};
        `REG_ID:       next_s.rdata = {28'h0, s.sid};
        `REG_OUT_STAT: next_s.rdata = {16'h0, s.out_stat};
        `REG_PEER_CFG: next_s.rdata = {16'h0, s.peer_cfg};
        `REG_FLAGS:    next_s.rdata = {online, 13'h0, s.tst == TX_SEND, s.peer_off,
                                       s.ring_break};
        `REG_RX_LAST:  next_s.rdata = {s.last_id, 8'h0, s.last_stat};
        `REG_IRQ_STAT: next_s.rdata = {28'h0, s.irq_stat};
        `REG_IRQ_MASK: next_s.rdata = {28'h0, s.irq_mask};
        default:       next_s.rdata = '0;
      endcase
    end

    ev[`IRQ_RX_MSG] = |ok;
    ev[`IRQ_CRC_ERR] = en && |(rx_bad & ((CHANNELS == 2) ? 2'b11 : 2'b01));
    ev[`IRQ_RING_BRK] = next_s.ring_break && !s.ring_break;
    ev[`IRQ_PEER_OFF] = next_s.peer_off && !s.peer_off;
    // set wins over a write-one clear
    next_s.irq_stat = (s.irq_stat & ~clr) | ev;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
      s.ctrl <= `CTRL_RESET;
      s.tx1 <= 1'b1;
      s.tx2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign ch1_tx_o = s.tx1;
  assign ch2_tx_o = s.tx2;
  assign ring_break_o = s.ring_break;
  assign peer_offline_o = s.peer_off;
  assign irq_o = s.irq;

endmodule : ring_status_message_exchange

/* File: verif/ring_monitor.sv */
// Purpose: port checks for the status ring exchange
// Assumes: one clock domain, bound to the top module
// Notes:   run counters catch bit-time slips on the lines
`timescale 1ns/1ps

module ring_monitor #(
  parameter int MS_CYC     = 40,
  parameter int TIMEOUT_MS = 1500
) (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic [3:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        we_i,
  input wire logic        re_i,
  input wire logic [31:0] rdata_o,
  input wire logic        ch1_rx_i,
  input wire logic        ch2_rx_i,
  input wire logic        ch1_tx_o,
  input wire logic        ch2_tx_o,
  input wire logic        ring_break_o,
  input wire logic        peer_offline_o,
  input wire logic        irq_o
);
  // first millisecond tick may land right after enable or a restart
  localparam int TO = (TIMEOUT_MS - 1) * MS_CYC;
  logic [9:0]  run1;
  logic [9:0]  run2;
  logic [31:0] up;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // full count at reset so the first start bit passes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run1 <= 10'h3FF;
      run2 <= 10'h3FF;
      up   <= 32'h0;
    end else begin
      run1 <= $changed(ch1_tx_o) ? 10'h0 : (run1 == 10'h3FF ? run1 : run1 + 10'h1);
      run2 <= $changed(ch2_tx_o) ? 10'h0 : (run2 == 10'h3FF ? run2 : run2 + 10'h1);
      up   <= up + 32'h1;
    end
  end

  a_rdata_idle: assert property (!$past(re_i) |-> rdata_o == 32'h0)
    else $error("read data outside its slot");
  a_reset_idle: assert property ($rose(arst_n_i) |->
      ch1_tx_o && ch2_tx_o && !irq_o && !ring_break_o && !peer_offline_o)
    else $error("outputs not idle after reset");
  a_ch1_bit: assert property ($changed(ch1_tx_o) |-> run1 >= 10'd311)
    else $error("ch1 level held shorter than a bit");
  a_ch2_bit: assert property ($changed(ch2_tx_o) |-> run2 >= 10'd311)
    else $error("ch2 level held shorter than a bit");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(we_i) || $past(we_i, 2))
    else $error("interrupt fell without a write");
  a_offline_late: assert property ($rose(peer_offline_o) |-> up >= TO)
    else $error("peer offline before timeout");
  a_break_late: assert property ($rose(ring_break_o) |-> up >= TO)
    else $error("ring break before timeout");
  a_flags_read: assert property ($past(re_i) && $past(addr_i) == 4'h4 |->
      rdata_o[1:0] == {$past(peer_offline_o), $past(ring_break_o)})
    else $error("flags read differs from flag outputs");

  c_frame: cover property ($fell(ch1_tx_o) && $fell(ch2_tx_o));
  c_offline: cover property ($rose(peer_offline_o));
  c_irq: cover property ($rose(irq_o));
endmodule : ring_monitor

bind ring_status_message_exchange ring_monitor #(
  .MS_CYC(MS_CYC),
  .TIMEOUT_MS(TIMEOUT_MS)
) mon (.*);

/* File: verif/ring_peer.sv */
// Purpose: far-end relay: sends frames, decodes frames heard
// Assumes: idle-high line, bit time in clk_i cycles
// Notes:   decoder samples mid-bit, flags crc and stop faults
`timescale 1ns/1ps
`include "ring_defs.svh"

module ring_peer #(
  parameter int BIT = 312
) (
  input  wire logic        clk_i,
  input  wire logic        tx_i,
  output logic             rx_o,
  output logic             got_o,
  output logic             ok_o,
  output logic [23:0]      frame_o
);
  logic [56:0] f;

  initial begin
    rx_o    = 1'b1;
    got_o   = 1'b0;
    ok_o    = 1'b0;
    frame_o = 24'h0;
  end

  function automatic logic [31:0] crc(input logic [23:0] d);
    logic [31:0] c;
    c = `CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `CRC_POLY : 32'h0);
    end
    return c;
  endfunction : crc

  // unique id, shared bit time; bad flips a crc bit
  task automatic send(input logic [7:0] id, input logic [15:0] st, input logic bad);
    logic [57:0] w;
    w = {1'b0, id, st, crc({id, st}) ^ {31'h0, bad}, 1'b1};
    for (int i = 57; i >= 0; i--) begin
      rx_o <= w[i];
      repeat (BIT) @(posedge clk_i);
    end
  endtask : send

  initial forever begin
    @(posedge clk_i iff tx_i === 1'b0);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 57; i++) begin
      repeat (BIT) @(posedge clk_i);
      f = {f[55:0], tx_i};
    end
    frame_o <= f[56:33];
    ok_o    <= (crc(f[56:33]) === f[32:1]) && (f[0] === 1'b1);
    got_o   <= 1'b1;
    @(posedge clk_i);
    got_o <= 1'b0;
  end
endmodule : ring_peer

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for the status ring exchange
// Assumes: 128k rate, shortened millisecond for run length
// Notes:   frames beyond the queued ones must be integrity frames
`timescale 1ns/1ps
`include "ring_defs.svh"

module tb_top;
  localparam int MSC = 80;
  logic        clk_i    = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [3:0]  addr_i   = 4'h0;
  logic [31:0] wdata_i  = 32'h0;
  logic        we_i     = 1'b0;
  logic        re_i     = 1'b0;
  logic        rd_pend  = 1'b0;
  logic [31:0] rdata_o;
  logic        ch1_rx, ch2_rx, ch1_tx, ch2_tx, brk, off, irq;
  logic        got [2];
  logic        ok [2];
  logic [23:0] frame [2];
  logic [63:0] rq [$];
  logic [23:0] fq [2][$];
  logic [15:0] st;
  logic [15:0] s5;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          last_own [2] = '{0, 0};

  always #12.5 clk_i = ~clk_i;

  ring_status_message_exchange #(.CHANNELS(2), .MS_CYC(MSC), .TIMEOUT_MS(1001)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .ch1_rx_i(ch1_rx), .ch2_rx_i(ch2_rx),
    .ch1_tx_o(ch1_tx), .ch2_tx_o(ch2_tx), .ring_break_o(brk), .peer_offline_o(off),
    .irq_o(irq));
  ring_peer p1 (.clk_i(clk_i), .tx_i(ch1_tx), .rx_o(ch1_rx), .got_o(got[0]),
    .ok_o(ok[0]), .frame_o(frame[0]));
  ring_peer p2 (.clk_i(clk_i), .tx_i(ch2_tx), .rx_o(ch2_rx), .got_o(got[1]),
    .ok_o(ok[1]), .frame_o(frame[1]));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({e, m});
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    @(posedge clk_i);
  endtask : rd

  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk_i) begin : watch
    logic [63:0] e;
    logic [23:0] x;
    cyc <= cyc + 1;
    if (rd_pend) begin
      e = rq.pop_front();
      chk(rdata_o & e[31:0], e[63:32]);
    end
    rd_pend <= re_i;
    for (int c = 0; c < 2; c++) begin
      if (got[c] === 1'b1) begin
        x = (fq[c].size() != 0) ? fq[c].pop_front() : {8'h03, st};
        chk({7'h0, ok[c], frame[c]}, {8'h01, x});
        if (frame[c][23:16] === 8'h03) begin
          chk({31'h0, (cyc - last_own[c]) <= 500 * MSC}, 32'h1);
          last_own[c] = cyc;
        end
      end
    end
  end

  initial begin
    #(98000 * 25);
    bad_count++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h94a9));
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int a = 0; a < 9; a++) begin
      // timers idle at zero while disabled, so every id reads online
      rd(4'((a == 8) ? 12 : a), (a == 4) ? 32'hFFFF0000 : 32'h0, 32'hFFFFFFFF);
    end
    wr(`REG_ID, 32'h3);
    wr(`REG_PEER_CFG, 32'h0220);
    wr(`REG_IRQ_MASK, 32'h8);
    wr(`REG_CTRL, 32'hF);
    rd(`REG_CTRL, 32'hF, 32'hFFFFFFFF);
    st = 16'($urandom) | 16'h1;
    s5 = 16'($urandom);
    for (int c = 0; c < 2; c++) begin
      fq[c].push_back({8'h03, st});
      fq[c].push_back({8'h05, s5});
    end
    wr(`REG_OUT_STAT, {16'h0, st});
    fork
      begin
        p1.send(8'h05, s5, 1'b0);
        p1.send(8'h05, ~s5, 1'b1);
      end
      p2.send(8'h03, ~st, 1'b0);
    join
    for (int i = 0; i < 90000 && off !== 1'b1; i++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    // own frame came back on ch2, so the ring is still whole here
    chk({29'h0, brk, off, irq}, 32'h3);
    rd(`REG_FLAGS, 32'h00200002, 32'h02200003);
    rd(`REG_IRQ_STAT, 32'hB, 32'hFFFFFFFB);
    wr(`REG_IRQ_STAT, 32'hF);
    wr(`REG_IRQ_MASK, 32'h0);
    rd(`REG_IRQ_STAT, 32'h0, 32'hFFFFFFFB);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    complete_run();
  end
endmodule : tb_top
